//--- bcr_cfg.svh
// constants for the boost controller configuration and register block
`ifndef BCR_CFG_SVH
`define BCR_CFG_SVH
// register offsets on the bus
`define BCR_A_STATUS 8'h00
`define BCR_A_CLEAR 8'h01
`define BCR_A_NEG_HI 8'h02
`define BCR_A_NEG_LO 8'h03
`define BCR_A_FB_HI 8'h04
`define BCR_A_FB_LO 8'h05
`define BCR_A_PH1_HI 8'h06
`define BCR_A_PH1_LO 8'h07
`define BCR_A_PH2_HI 8'h08
`define BCR_A_PH2_LO 8'h09
`define BCR_A_OC 8'h0A
`define BCR_A_REF_HI 8'h0B
`define BCR_A_REF_LO 8'h0C
// fixed upper part of the bus target address
`define BCR_ADDR_HI 4'hA
// status bit positions: fault bits and the chip role bit
`define BCR_SB_SHARE 7
`define BCR_SB_ROLE 6
`define BCR_SB_FBOV 5
`define BCR_SB_PH2 4
`define BCR_SB_PH1 3
`define BCR_SB_EN 2
`define BCR_SB_OT 1
`define BCR_SB_PWR 0
// positions in the synchronised pin vector
`define BCR_P_BIAS 15
`define BCR_P_OT 14
`define BCR_P_SHARE 13
`define BCR_P_EN 12
`define BCR_P_PWR 11
`define BCR_P_LG 9
`define BCR_P_FRQ 8
`define BCR_P_OVP 4
`define BCR_P_ADR 1
`define BCR_P_ROLE 0
// reset values
`define BCR_OC_RST 8'h00
`define BCR_REF_RST 10'h000
// last legal overvoltage strap level
`define BCR_STRAP_MAX 4'hB
// phase offsets in degrees
`define BCR_DEG_0 9'h000
`define BCR_DEG_90 9'h05A
`define BCR_DEG_120 9'h078
`define BCR_DEG_180 9'h0B4
`define BCR_DEG_240 9'h0F0
`define BCR_DEG_270 9'h10E
// timing
`define BCR_CLK_NS 100
`define BCR_SAMPLE_US 3200
`define BCR_SAMPLE_CYC (`BCR_SAMPLE_US * 1000 / `BCR_CLK_NS)
`endif

//--- bcr_pkg.sv
// types for the boost controller configuration and register block
package bcr_pkg;
    typedef enum logic [1:0] {BCR_PH_MULTI, BCR_PH_SINGLE, BCR_PH_TRIPLE}
        bcr_phase_t;
    typedef enum logic {BCR_TH_RUN, BCR_TH_SHUT} bcr_therm_t;
    typedef enum logic [2:0] {BCR_I_IDLE, BCR_I_ADDR, BCR_I_AACK, BCR_I_PTR,
        BCR_I_WACK, BCR_I_WDATA, BCR_I_RDATA, BCR_I_RACK} bcr_i2c_t;
    typedef struct packed {
        logic [7:0] status;
        logic [39:0] smp;
        logic [7:0] oc;
        logic [9:0] ref_set;
        logic [2:0] addr_lo;
    } bcr_snap_t;
    typedef struct packed {
        logic [15:0] pin1;
        logic [15:0] pin2;
        logic strap_done;
        logic [3:0] ovp_code;
        logic [2:0] addr_lo;
        logic primary;
        logic freq_open;
        logic [7:0] status;
        logic [7:0] oc;
        logic [9:0] ref_set;
        logic [39:0] smp;
        logic [15:0] cnt;
        bcr_snap_t pub;
        logic pub_tgl;
        logic ack1;
        logic ack2;
        logic wr1;
        logic wr2;
        logic wr3;
        bcr_therm_t th;
        logic drv_en;
        logic ss_dis;
        logic ss_start;
        logic [1:0] hs;
        logic ov_chk;
        logic shifter;
        bcr_phase_t mode;
        logic [8:0] ph1_deg;
        logic [8:0] ph2_deg;
        logic ph2_act;
        logic freq_preset;
        logic ocp_from_reg;
        logic ref_from_reg;
    } bcr_sys_t;
    typedef struct packed {
        logic pub1;
        logic pub2;
        bcr_snap_t cp;
        logic seen;
        bcr_i2c_t st;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic rw;
        logic ack_tgl;
        logic wr_tgl;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic oe_want;
    } bcr_lnk_t;
endpackage

//--- bcr_top.sv
// configuration, thermal restart and bus register bank of the boost controller
`include "bcr_cfg.svh"
module bcr_top #(
    parameter int SAMPLE_CYC = `BCR_SAMPLE_CYC
) (
    // system clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // bus pins, open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // asynchronous pins and straps
    input wire logic bias_low,
    input wire logic ot_hot,
    input wire logic share_bus_negative_line,
    input wire logic enable_lockout_input,
    input wire logic power_ok_low,
    input wire logic [1:0] low_gate_sense_pins,
    input wire logic rate_select_pin_open,
    input wire logic [3:0] overvoltage_strap_pin,
    input wire logic [2:0] addr_strap_level,
    input wire logic primary_role,
    // same-clock fault flags and requests
    input wire logic feedback_overvoltage_flag,
    input wire logic first_phase_overcurrent_flag,
    input wire logic second_phase_overcurrent_flag,
    input wire logic [1:0] hs_request,
    // same-clock measurement codes
    input wire logic [9:0] negative_output_code,
    input wire logic [9:0] feedback_code,
    input wire logic [9:0] first_phase_current_code,
    input wire logic [9:0] second_phase_current_code,
    // power stage control
    output logic drv_enable,
    output logic ss_discharge,
    output logic ss_restart,
    output logic [1:0] hs_drive,
    // decoded configuration
    output logic ov_check_en,
    output logic level_shift_en,
    output logic [1:0] phase_mode,
    output logic [8:0] phase1_offset_deg,
    output logic [8:0] phase2_offset_deg,
    output logic phase2_active,
    output logic freq_preset_300k,
    // limit and reference handover
    output logic [7:0] overcurrent_code,
    output logic ocp_from_reg,
    output logic [9:0] ref_code,
    output logic ref_from_reg
);
    bcr_pkg::bcr_sys_t r;
    bcr_pkg::bcr_sys_t n;
    bcr_pkg::bcr_lnk_t l;
    bcr_pkg::bcr_lnk_t ln;
    logic wr_ev;
    logic clr;
    logic [7:0] set_v;
    logic [3:0] dec;
    logic [7:0] byte_in;
    logic [7:0] rd;
    logic start_tgl;
    logic lrst1;
    logic lrst2;
    logic oe_r;

    // strap level to {mode, check, shifter}; unused levels act as open
    function automatic logic [3:0] ovp_decode(input logic [3:0] c);
        logic [3:0] k;
        k = (c > `BCR_STRAP_MAX) ? `BCR_STRAP_MAX : c;
        return {k[3:2], ~k[1], k[0]};
    endfunction

    // read mux over the link-side snapshot
    function automatic logic [7:0] rd_byte(input logic [7:0] a,
                                           input bcr_pkg::bcr_snap_t s);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `BCR_A_STATUS: v = s.status;
            `BCR_A_NEG_HI: v = {6'h00, s.smp[39:38]};
            `BCR_A_NEG_LO: v = s.smp[37:30];
            `BCR_A_FB_HI: v = {6'h00, s.smp[29:28]};
            `BCR_A_FB_LO: v = s.smp[27:20];
            `BCR_A_PH1_HI: v = {6'h00, s.smp[19:18]};
            `BCR_A_PH1_LO: v = s.smp[17:10];
            `BCR_A_PH2_HI: v = {6'h00, s.smp[9:8]};
            `BCR_A_PH2_LO: v = s.smp[7:0];
            `BCR_A_OC: v = s.oc;
            `BCR_A_REF_HI: v = {6'h00, s.ref_set[9:8]};
            `BCR_A_REF_LO: v = s.ref_set[7:0];
            default: v = 8'h00; // clear register and unmapped read as zero
        endcase
        return v;
    endfunction

    // system-side next state
    always_comb begin
        n = r;
        n.pin1 = {bias_low, ot_hot, share_bus_negative_line,
                  enable_lockout_input, power_ok_low, low_gate_sense_pins,
                  rate_select_pin_open, overvoltage_strap_pin,
                  addr_strap_level, primary_role};
        n.pin2 = r.pin1;
        n.ack1 = l.ack_tgl;
        n.ack2 = r.ack1;
        n.wr1 = l.wr_tgl;
        n.wr2 = r.wr1;
        n.wr3 = r.wr2;
        // write address and data are held by the link until the next toggle
        wr_ev = r.wr2 ^ r.wr3;
        // straps caught once, first cycle after reset release
        if (!r.strap_done) begin
            n.strap_done = 1'b1;
            n.ovp_code = r.pin2[`BCR_P_OVP+3:`BCR_P_OVP];
            n.addr_lo = r.pin2[`BCR_P_ADR+2:`BCR_P_ADR];
            n.primary = r.pin2[`BCR_P_ROLE];
            n.freq_open = r.pin2[`BCR_P_FRQ];
        end
        dec = ovp_decode(n.ovp_code);
        n.mode = bcr_pkg::bcr_phase_t'(dec[3:2]);
        n.ov_chk = dec[1];
        n.shifter = dec[0];
        n.freq_preset = n.freq_open;
        // phase placement per mode and chip role
        unique case (n.mode)
            bcr_pkg::BCR_PH_MULTI: begin
                n.ph1_deg = n.primary ? `BCR_DEG_0 : `BCR_DEG_90;
                n.ph2_deg = n.primary ? `BCR_DEG_180 : `BCR_DEG_270;
                n.ph2_act = 1'b1;
            end
            bcr_pkg::BCR_PH_SINGLE: begin
                n.ph1_deg = `BCR_DEG_0;
                n.ph2_deg = `BCR_DEG_0;
                n.ph2_act = 1'b0;
            end
            default: begin
                n.ph1_deg = n.primary ? `BCR_DEG_0 : `BCR_DEG_120;
                n.ph2_deg = n.primary ? `BCR_DEG_240 : `BCR_DEG_0;
                n.ph2_act = n.primary;
            end
        endcase
        // thermal shutdown; the sensor supplies its own hysteresis
        unique case (r.th)
            bcr_pkg::BCR_TH_RUN:
                if (r.pin2[`BCR_P_OT]) n.th = bcr_pkg::BCR_TH_SHUT;
            bcr_pkg::BCR_TH_SHUT:
                if (!r.pin2[`BCR_P_OT]) n.th = bcr_pkg::BCR_TH_RUN;
        endcase
        n.ss_start = (r.th == bcr_pkg::BCR_TH_SHUT) &&
                     (n.th == bcr_pkg::BCR_TH_RUN);
        n.drv_en = (n.th == bcr_pkg::BCR_TH_RUN);
        n.ss_dis = (n.th == bcr_pkg::BCR_TH_SHUT);
        // high side only after low gate reads off
        n.hs = hs_request & ~r.pin2[`BCR_P_LG+1:`BCR_P_LG] &
               {n.ph2_act, 1'b1} & {2{n.drv_en}};
        // sticky faults; a fault present in the clear cycle stays set
        clr = wr_ev && (l.wr_addr == `BCR_A_CLEAR);
        set_v = 8'h00;
        set_v[`BCR_SB_SHARE] = r.pin2[`BCR_P_SHARE];
        set_v[`BCR_SB_FBOV] = feedback_overvoltage_flag;
        set_v[`BCR_SB_PH2] = second_phase_overcurrent_flag;
        set_v[`BCR_SB_PH1] = first_phase_overcurrent_flag;
        set_v[`BCR_SB_EN] = r.pin2[`BCR_P_EN];
        set_v[`BCR_SB_OT] = r.pin2[`BCR_P_OT];
        set_v[`BCR_SB_PWR] = r.pin2[`BCR_P_PWR];
        n.status = (r.status & ~{8{clr}}) | set_v;
        n.status[`BCR_SB_ROLE] = n.primary;
        // register writes from the bus
        if (wr_ev) begin
            unique case (l.wr_addr)
                `BCR_A_OC: n.oc = l.wr_data;
                `BCR_A_REF_HI: n.ref_set[9:8] = l.wr_data[1:0];
                `BCR_A_REF_LO: n.ref_set[7:0] = l.wr_data;
                default: ;
            endcase
        end
        // periodic sample of all four codes at once
        if (r.cnt == 16'(SAMPLE_CYC - 1)) begin
            n.cnt = 16'h0000;
            n.smp = {negative_output_code, feedback_code,
                     first_phase_current_code,
                     second_phase_current_code};
        end else begin
            n.cnt = r.cnt + 16'h0001;
        end
        // low bias wipes the bank
        if (r.pin2[`BCR_P_BIAS]) begin
            n.status = 8'h00;
            n.oc = `BCR_OC_RST;
            n.ref_set = `BCR_REF_RST;
            n.smp = 40'h00_0000_0000;
        end
        n.ocp_from_reg = (n.oc != 8'h00);
        n.ref_from_reg = (n.ref_set != 10'h000);
        // new snapshot only once the link took the last one
        if (r.ack2 == r.pub_tgl) begin
            n.pub = {n.status, n.smp, n.oc, n.ref_set, n.addr_lo};
            n.pub_tgl = ~r.pub_tgl;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            // pin synchronisers keep running so straps are valid at release
            r <= '0;
            r.pin1 <= n.pin1;
            r.pin2 <= n.pin2;
        end else begin
            r <= n;
        end
    end

    // start marker: sda falling while scl high; async clear from resetn
    always_ff @(negedge sda_in or negedge resetn) begin
        if (!resetn) begin
            start_tgl <= 1'b0;
        end else if (scl_in) begin
            start_tgl <= ~start_tgl;
        end
    end

    // reset brought into the link clock
    always_ff @(posedge scl_in) begin
        lrst1 <= resetn;
        lrst2 <= lrst1;
    end

    // link-side next state; start_tgl settles half a bit before use
    always_comb begin
        ln = l;
        ln.pub1 = r.pub_tgl;
        ln.pub2 = l.pub1;
        ln.oe_want = 1'b0;
        byte_in = {l.sh[6:0], sda_in};
        rd = rd_byte(l.ptr, l.cp);
        // snapshot held still by mclk until acknowledged
        if (l.st == bcr_pkg::BCR_I_ADDR && l.pub2 != l.ack_tgl) begin
            ln.cp = r.pub;
            ln.ack_tgl = l.pub2;
        end
        if (start_tgl != l.seen) begin
            ln.seen = start_tgl;
            ln.st = bcr_pkg::BCR_I_ADDR;
            ln.sh = {7'h00, sda_in};
            ln.cnt = 3'h1;
        end else begin
            unique case (l.st)
                bcr_pkg::BCR_I_IDLE: ;
                bcr_pkg::BCR_I_ADDR, bcr_pkg::BCR_I_PTR,
                bcr_pkg::BCR_I_WDATA: begin
                    ln.sh = byte_in;
                    ln.cnt = l.cnt + 3'h1;
                    if (l.cnt == 3'h7) begin
                        ln.oe_want = 1'b1;
                        if (l.st == bcr_pkg::BCR_I_ADDR) begin
                            ln.rw = byte_in[0];
                            if (byte_in[7:1] ==
                                {`BCR_ADDR_HI, l.cp.addr_lo}) begin
                                ln.st = bcr_pkg::BCR_I_AACK;
                            end else begin
                                ln.st = bcr_pkg::BCR_I_IDLE;
                                ln.oe_want = 1'b0;
                            end
                        end else if (l.st == bcr_pkg::BCR_I_PTR) begin
                            ln.ptr = byte_in;
                            ln.st = bcr_pkg::BCR_I_WACK;
                        end else begin
                            ln.wr_addr = l.ptr;
                            ln.wr_data = byte_in;
                            ln.wr_tgl = ~l.wr_tgl;
                            ln.ptr = l.ptr + 8'h01;
                            ln.st = bcr_pkg::BCR_I_WACK;
                        end
                    end
                end
                bcr_pkg::BCR_I_AACK: begin
                    ln.cnt = 3'h0;
                    if (l.rw) begin
                        ln.sh = rd;
                        ln.ptr = l.ptr + 8'h01;
                        ln.oe_want = ~rd[7];
                        ln.st = bcr_pkg::BCR_I_RDATA;
                    end else begin
                        ln.st = bcr_pkg::BCR_I_PTR;
                    end
                end
                bcr_pkg::BCR_I_WACK: begin
                    ln.cnt = 3'h0;
                    ln.st = bcr_pkg::BCR_I_WDATA;
                end
                bcr_pkg::BCR_I_RDATA: begin
                    ln.sh = {l.sh[6:0], 1'b0};
                    ln.cnt = l.cnt + 3'h1;
                    if (l.cnt == 3'h7) begin
                        ln.st = bcr_pkg::BCR_I_RACK;
                    end else begin
                        ln.oe_want = ~l.sh[6];
                    end
                end
                default: begin
                    // host ack keeps the read going, nack ends it
                    ln.cnt = 3'h0;
                    if (!sda_in) begin
                        ln.sh = rd;
                        ln.ptr = l.ptr + 8'h01;
                        ln.oe_want = ~rd[7];
                        ln.st = bcr_pkg::BCR_I_RDATA;
                    end else begin
                        ln.st = bcr_pkg::BCR_I_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge scl_in) begin
        if (!lrst2) begin
            l <= '0;
        end else begin
            l <= ln;
        end
    end

    // data changes only while scl is low
    always_ff @(negedge scl_in) begin
        if (!lrst2) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= l.oe_want;
        end
    end

    // outputs straight from flops, except sda_out tied low
    assign sda_oe = oe_r;
    assign sda_out = 1'b0;
    assign drv_enable = r.drv_en;
    assign ss_discharge = r.ss_dis;
    assign ss_restart = r.ss_start;
    assign hs_drive = r.hs;
    assign ov_check_en = r.ov_chk;
    assign level_shift_en = r.shifter;
    assign phase_mode = r.mode;
    assign phase1_offset_deg = r.ph1_deg;
    assign phase2_offset_deg = r.ph2_deg;
    assign phase2_active = r.ph2_act;
    assign freq_preset_300k = r.freq_preset;
    assign overcurrent_code = r.oc;
    assign ocp_from_reg = r.ocp_from_reg;
    assign ref_code = r.ref_set;
    assign ref_from_reg = r.ref_from_reg;

    // checks on the system side
    property p_hs_gate;
        @(posedge mclk) disable iff (!resetn)
        r.hs[0] |-> !$past(r.pin2[`BCR_P_LG]) && r.drv_en;
    endproperty
    a_hs_gate: assert property (p_hs_gate)
        else $error("high side on while low gate sensed on");
    property p_ot_off;
        @(posedge mclk) disable iff (!resetn)
        r.pin2[`BCR_P_OT] |=> !r.drv_en && r.ss_dis;
    endproperty
    a_ot_off: assert property (p_ot_off)
        else $error("drivers not stopped on over-temperature");
    property p_ot_restart;
        @(posedge mclk) disable iff (!resetn)
        $fell(r.ss_dis) |-> r.ss_start ##1 !r.ss_start;
    endproperty
    a_ot_restart: assert property (p_ot_restart)
        else $error("no single soft-start pulse on recovery");
    property p_set_wins;
        @(posedge mclk) disable iff (!resetn)
        feedback_overvoltage_flag && !r.pin2[`BCR_P_BIAS] |=> r.status[5];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("overvoltage fault bit lost");
    property p_oc_hand;
        @(posedge mclk) disable iff (!resetn)
        ##1 r.ocp_from_reg == (r.oc != 8'h00);
    endproperty
    a_oc_hand: assert property (p_oc_hand)
        else $error("limit source does not follow register");
    property p_ref_hand;
        @(posedge mclk) disable iff (!resetn)
        ##1 r.ref_from_reg == (r.ref_set != 10'h000);
    endproperty
    a_ref_hand: assert property (p_ref_hand)
        else $error("reference source does not follow register");
    property p_bias_wipe;
        @(posedge mclk) disable iff (!resetn)
        r.pin2[`BCR_P_BIAS] |=> r.oc == 8'h00 && r.ref_set == 10'h000
            && !ocp_from_reg;
    endproperty
    a_bias_wipe: assert property (p_bias_wipe)
        else $error("registers kept through low bias");
    property p_sample;
        @(posedge mclk) disable iff (!resetn)
        r.cnt == 16'(SAMPLE_CYC - 1) && !r.pin2[`BCR_P_BIAS] |=>
            r.smp[9:0] == $past(second_phase_current_code) && r.cnt == 0;
    endproperty
    a_sample: assert property (p_sample)
        else $error("readback not refreshed at period end");
    property p_triple;
        @(posedge mclk) disable iff (!resetn)
        r.mode == bcr_pkg::BCR_PH_TRIPLE |-> (r.primary ?
            r.ph2_deg == 9'h0F0 : (r.ph1_deg == 9'h078 && !r.ph2_act));
    endproperty
    a_triple: assert property (p_triple)
        else $error("triple phase offsets wrong");
endmodule

//--- bcr_host.sv
// two-wire bus host model that drives the register bank
module bcr_host (
    // bus lines
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    // both lines idle high, and the clock stands still outside frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // one bus bit: data changes only while the clock is low
    task automatic clk_bit(input logic b, output logic seen);
        sda_pull = !b;
        #12 scl = 1'b1;
        #12 seen = sda;
        #12 scl = 1'b0;
        #12;
    endtask
    // start or repeated start, data falls while the clock is high
    task automatic start();
        sda_pull = 1'b0;
        #12 scl = 1'b1;
        #12 sda_pull = 1'b1;
        #12 scl = 1'b0;
        #12;
    endtask
    // stop: data rises while the clock is high
    task automatic stop();
        sda_pull = 1'b1;
        #12 scl = 1'b1;
        #12 sda_pull = 1'b0;
        #24;
    endtask
    // a byte msb first, then the ninth bit with the line released
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
        output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], s);
            rx[i] = s;
        end
        clk_bit(1'b1, s);
        ack = !s;
    endtask
endmodule

//--- boost_ctrl_config_and_i2c_regs_test.sv
// self-checking bench for the boost controller register bank
`include "bcr_cfg.svh"
module boost_ctrl_config_and_i2c_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, resetn = 0, scl_in, pull, bias_low = 0, ot_hot = 0;
    logic share_bus_negative_line = 0, enable_lockout_input = 0;
    logic power_ok_low = 0, rate_select_pin_open = 0, primary_role = 1;
    logic feedback_overvoltage_flag = 0, first_phase_overcurrent_flag = 0;
    logic second_phase_overcurrent_flag = 0;
    logic [1:0] low_gate_sense_pins = 0, hs_request = 0;
    logic [3:0] overvoltage_strap_pin = 0;
    logic [2:0] addr_strap_level = 3'h5;
    logic [9:0] negative_output_code = 10'h2C3, feedback_code = 10'h17E;
    logic [9:0] first_phase_current_code = 10'h0A9;
    logic [9:0] second_phase_current_code = 10'h35A;
    logic sda_out, sda_oe, drv_enable, ss_discharge, ss_restart;
    logic ov_check_en, level_shift_en, phase2_active, freq_preset_300k;
    logic ocp_from_reg, ref_from_reg;
    logic [1:0] hs_drive, phase_mode;
    logic [8:0] phase1_offset_deg, phase2_offset_deg;
    logic [7:0] overcurrent_code, x;
    logic [9:0] ref_code;
    logic k;
    int n_errors = 0;
    int n_tests = 0;
    // open-drain wire with pull-up
    wire sda_in = !(pull | sda_oe);
    logic [24:0] rows [11] = '{
        {1'b0, `BCR_A_OC, 8'h00, 8'h00}, {1'b0, `BCR_A_REF_LO, 8'h00, 8'h00},
        {1'b1, `BCR_A_OC, 8'h55, 8'h55}, {1'b1, `BCR_A_REF_HI, 8'hFF, 8'h03},
        {1'b1, `BCR_A_REF_LO, 8'hA5, 8'hA5}, {1'b1, `BCR_A_CLEAR, 8'h00, 8'h00},
        {1'b1, `BCR_A_NEG_LO, 8'h12, 8'hC3}, {1'b0, `BCR_A_NEG_HI, 8'h0, 8'h02},
        {1'b0, `BCR_A_FB_LO, 8'h00, 8'h7E}, {1'b0, `BCR_A_PH2_HI, 8'h0, 8'h03},
        {1'b0, 8'h0D, 8'h00, 8'h00}};
    // strap, mode, check, shifter, phase2 on, phase2 offset
    logic [17:0] straps [4] = '{{4'h1, 5'b00111, 9'h0B4},
        {4'h6, 5'b01000, 9'h000}, {4'h9, 5'b10111, 9'h0F0},
        {4'hE, 5'b10011, 9'h0F0}};
    bcr_top #(.SAMPLE_CYC(16)) DUT (.*);
    bcr_host host (.scl(scl_in), .sda_pull(pull), .sda(sda_in));
    always #50 mclk = ~mclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // link reset needs bus clock edges while reset is low
    task automatic do_reset(input logic [3:0] s, input logic fo);
        @(posedge mclk);
        resetn <= 1'b0;
        overvoltage_strap_pin <= s;
        rate_select_pin_open <= fo;
        host.clk_bit(1'b1, k);
        host.clk_bit(1'b1, k);
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        repeat (6) @(posedge mclk);
        host.clk_bit(1'b1, k);
        host.clk_bit(1'b1, k);
    endtask
    // pointer write, optional data, then read back after repeated start
    task automatic reg_rw(input logic [7:0] a, input logic [7:0] d,
        input logic wr, output logic [7:0] rd);
        logic [7:0] t;
        logic ak;
        // write lands some mclk later; snapshot is refreshed a frame after
        if (wr) begin
            host.start();
            host.xfer({`BCR_ADDR_HI, addr_strap_level, 1'b0}, t, ak);
            host.xfer(a, t, ak);
            host.xfer(d, t, ak);
            check(ak, 1'b1);
            host.stop();
            repeat (8) @(posedge mclk);
        end
        host.start();
        host.xfer({`BCR_ADDR_HI, addr_strap_level, 1'b0}, t, ak);
        check(ak, 1'b1);
        host.xfer(a, t, ak);
        host.start();
        host.xfer({`BCR_ADDR_HI, addr_strap_level, 1'b1}, t, ak);
        host.xfer(8'hFF, rd, ak);
        host.stop();
    endtask
    // a hang counts as a mismatch
    initial begin
        #3000000;
        n_errors++;
        complete_run();
    end
    initial begin
        do_reset(4'h9, 1'b1);
        foreach (rows[i]) begin
            reg_rw(rows[i][23:16], rows[i][15:8], rows[i][24], x);
            check(x, rows[i][7:0]);
        end
        check({ocp_from_reg, overcurrent_code}, 9'h155);
        check({ref_from_reg, ref_code}, 11'h7A5);
        // other targets, upper and lower part of the address wrong
        foreach (straps[i]) begin
            host.start();
            host.xfer({4'hA ^ 4'(i % 2 ? 0 : 1), 3'h5 ^ 3'(i), 1'b0}, x, k);
            host.stop();
            check(k, 1'b0);
        end
        @(posedge mclk);
        first_phase_overcurrent_flag <= 1'b1;
        feedback_overvoltage_flag <= 1'b1;
        @(posedge mclk);
        feedback_overvoltage_flag <= 1'b0;
        reg_rw(`BCR_A_STATUS, 8'h00, 1'b0, x);
        check(x, 8'h68);
        reg_rw(`BCR_A_CLEAR, 8'h00, 1'b1, x);
        reg_rw(`BCR_A_STATUS, 8'h00, 1'b0, x);
        check(x, 8'h48);
        first_phase_overcurrent_flag <= 1'b0;
        ot_hot <= 1'b1;
        repeat (4) @(posedge mclk);
        check({drv_enable, ss_discharge}, 2'b01);
        ot_hot <= 1'b0;
        k = 1'b0;
        repeat (8) begin
            @(posedge mclk);
            #1 k = k | ss_restart;
        end
        check({k, drv_enable, ss_discharge}, 3'b110);
        hs_request <= 2'b11;
        repeat (4) @(posedge mclk);
        check(hs_drive, 2'b11);
        low_gate_sense_pins <= 2'b01;
        repeat (4) @(posedge mclk);
        check(hs_drive, 2'b10);
        bias_low <= 1'b1;
        repeat (4) @(posedge mclk);
        bias_low <= 1'b0;
        repeat (4) @(posedge mclk);
        check({ocp_from_reg, ref_from_reg, ref_code}, 12'h000);
        reg_rw(`BCR_A_OC, 8'h00, 1'b0, x);
        check(x, 8'h00);
        foreach (straps[i]) begin
            do_reset(straps[i][17:14], i[0]);
            check({phase_mode, ov_check_en, level_shift_en, phase2_active,
                phase2_offset_deg, phase1_offset_deg, freq_preset_300k},
                {straps[i][13:0], 9'h000, i[0]});
        end
        // secondary chip, multi and triple straps 4'h0 and 4'h8
        primary_role <= 1'b0;
        do_reset(4'h0, 1'b0);
        check({phase1_offset_deg, phase2_offset_deg, phase2_active},
            {9'h05A, 9'h10E, 1'b1});
        do_reset(4'h8, 1'b0);
        check({phase1_offset_deg, phase2_offset_deg, phase2_active},
            {9'h078, 9'h000, 1'b0});
        complete_run();
    end
endmodule
